/* File: common/flash_prot_pkg.sv */
// Constants and carrier types for the flash block protection logic
package flash_prot_pkg;
   localparam int WORD_W = 32;
   localparam int ADDR_W = 15;
   localparam int ARRAY_BYTES = 98304;
   localparam int WORD_BYTES = 4;
   localparam int ARRAY_WORDS = ARRAY_BYTES / WORD_BYTES;
   localparam int ERASE_BYTES = 1024;
   localparam int ERASE_WORDS = ERASE_BYTES / WORD_BYTES;
   localparam int ERASE_LSB = 8;
   localparam int BLOCK_W = ADDR_W - ERASE_LSB;
   localparam int REGION_LSB = 9;
   localparam int REGION_W = ADDR_W - REGION_LSB;
   localparam int REGIONS = ARRAY_WORDS * WORD_BYTES / (2 * ERASE_BYTES);
   localparam logic [ADDR_W-1:0] LAST_WORD = 15'h5fff;
   localparam logic [ERASE_LSB-1:0] LAST_OFFSET = 8'hff;
   localparam logic [WORD_W-1:0] ERASED_WORD = 32'hffffffff;
   localparam logic [WORD_W-1:0] DENIED_WORD = 32'h00000000;

   typedef enum logic [1:0] {
      ATTR_OPEN = 2'h0,
      ATTR_READ_ONLY = 2'h1,
      ATTR_EXEC_ONLY = 2'h2
   } attr_t;

   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_PROGRAM = 2'h1,
      OP_ERASE = 2'h2
   } op_kind_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'h0,
      ST_ERASE = 1'h1
   } op_state_t;

   typedef struct packed {
      logic valid;
      logic debug;
      logic [ADDR_W-1:0] addr;
   } read_req_t;

   typedef struct packed {
      logic ack;
      logic denied;
      logic [WORD_W-1:0] data;
   } read_rsp_t;

   typedef struct packed {
      op_kind_t kind;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } op_req_t;

   typedef struct packed {
      logic we;
      logic [REGION_W-1:0] region;
      attr_t attr;
   } attr_req_t;
endpackage

/* File: hw/region_permit.sv */
// Permission decode for one access against its region attribute
`timescale 1ns/100ps
module region_permit
(
   // Access
   input wire logic [flash_prot_pkg::ADDR_W-1:0] addr,
   input wire logic [2*flash_prot_pkg::REGIONS-1:0] attr_flat,
   // Permissions
   output logic in_range,
   output logic allow_fetch,
   output logic allow_data,
   output logic allow_modify
);
   wire logic [flash_prot_pkg::REGION_W-1:0] region;
   wire logic [1:0] attr;
   assign region = addr[flash_prot_pkg::ADDR_W-1:flash_prot_pkg::REGION_LSB];
   assign in_range = addr <= flash_prot_pkg::LAST_WORD;
   assign attr = in_range ? attr_flat[2*region +: 2] : flash_prot_pkg::ATTR_OPEN;
   assign allow_fetch = in_range;
   assign allow_data = in_range && (attr != flash_prot_pkg::ATTR_EXEC_ONLY);
   assign allow_modify = in_range && (attr == flash_prot_pkg::ATTR_OPEN);
endmodule // region_permit

/* File: hw/flash_block_protection.sv */
// Flash array with erase blocks, region attributes and guarded access paths
// Operation
// - 96 KB array in 1 KB erase units
// - Erase sets every unit bit to one
// - Two erase units share one protection region
// - Each region has own selectable attribute
// - Read-only region refuses erase and program
// - Execute-only serves fetches only, refuses changes
// - Permitted reads finish in one cycle
`timescale 1ns/100ps
module flash_block_protection
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Instruction fetch
   input wire flash_prot_pkg::read_req_t fetch_req,
   output flash_prot_pkg::read_rsp_t fetch_rsp,
   // Data and debugger reads
   input wire flash_prot_pkg::read_req_t data_req,
   output flash_prot_pkg::read_rsp_t data_rsp,
   // Program and erase
   input wire flash_prot_pkg::op_req_t op_req,
   output logic op_busy,
   output logic op_done,
   output logic op_refused,
   // Attributes
   input wire flash_prot_pkg::attr_req_t attr_req,
   // Violation flag
   input wire logic violation_clear,
   output logic violation
);
   logic [flash_prot_pkg::WORD_W-1:0] array_mem [flash_prot_pkg::ARRAY_WORDS];
   logic [2*flash_prot_pkg::REGIONS-1:0] attr_flat;
   flash_prot_pkg::op_state_t state;
   logic [flash_prot_pkg::BLOCK_W-1:0] erase_block;
   logic [flash_prot_pkg::ERASE_LSB-1:0] erase_offset;

   // Each port decodes its own address; all three share one attribute store
   wire logic fetch_ok;
   wire logic data_ok;
   wire logic op_ok;

   region_permit u_fetch_permit
   (
      .addr(fetch_req.addr),
      .attr_flat(attr_flat),
      .in_range(),
      .allow_fetch(fetch_ok),
      .allow_data(),
      .allow_modify()
   );

   region_permit u_data_permit
   (
      .addr(data_req.addr),
      .attr_flat(attr_flat),
      .in_range(),
      .allow_fetch(),
      .allow_data(data_ok),
      .allow_modify()
   );

   region_permit u_op_permit
   (
      .addr(op_req.addr),
      .attr_flat(attr_flat),
      .in_range(),
      .allow_fetch(),
      .allow_data(),
      .allow_modify(op_ok)
   );

   // Operation acceptance
   wire logic idle;
   wire logic op_asked;
   wire logic op_accept;
   wire logic op_reject;
   wire logic start_erase;
   wire logic do_program;
   wire logic erase_last;
   wire logic data_bad;
   wire logic fetch_bad;
   wire logic new_violation;
   wire logic next_violation;
   wire logic op_finish;
   assign idle = state == flash_prot_pkg::ST_IDLE;
   // Requests during an erase are dropped, not queued
   assign op_asked = idle && (op_req.kind != flash_prot_pkg::OP_NONE);
   assign op_accept = op_asked && op_ok;
   assign op_reject = op_asked && !op_ok;
   assign start_erase = op_accept && (op_req.kind == flash_prot_pkg::OP_ERASE);
   assign do_program = op_accept && (op_req.kind == flash_prot_pkg::OP_PROGRAM);
   // Last word of the unit under erase
   assign erase_last = erase_offset == flash_prot_pkg::LAST_OFFSET;
   assign data_bad = data_req.valid && !data_ok;
   // Fetches beyond the array are refused too
   assign fetch_bad = fetch_req.valid && !fetch_ok;
   assign new_violation = op_reject || data_bad || fetch_bad;
   // Set wins over a clear in the same cycle
   assign next_violation = new_violation || (violation && !violation_clear);
   // Program finishes at once, erase after its last word
   assign op_finish = do_program || ((state == flash_prot_pkg::ST_ERASE) && erase_last);

   // Write port address, one word per cycle
   wire logic [flash_prot_pkg::ADDR_W-1:0] erase_addr;
   assign erase_addr = {erase_block, erase_offset};

   // Next state
   flash_prot_pkg::op_state_t next_state;
   always_comb
   begin
      next_state = state;
      case (state)
         flash_prot_pkg::ST_IDLE:
         begin
            if (start_erase)
               next_state = flash_prot_pkg::ST_ERASE;
         end
         flash_prot_pkg::ST_ERASE:
         begin
            if (erase_last)
               next_state = flash_prot_pkg::ST_IDLE;
         end
         default: next_state = flash_prot_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         state <= flash_prot_pkg::ST_IDLE;
         erase_block <= '0;
         erase_offset <= '0;
      end
      else
      begin
         state <= next_state;
         if (start_erase)
            erase_block <= op_req.addr[flash_prot_pkg::ADDR_W-1:flash_prot_pkg::ERASE_LSB];
         if (state == flash_prot_pkg::ST_ERASE)
            erase_offset <= erase_offset + 8'h01;
         else
            erase_offset <= '0;
      end
   end

   // Array writes; erase walks only its own unit
   // No reset here: flash keeps its contents across one
   always_ff @(posedge core_clk)
   begin
      if (state == flash_prot_pkg::ST_ERASE)
         array_mem[erase_addr] <= flash_prot_pkg::ERASED_WORD;
      else if (do_program)
         array_mem[op_req.addr] <= op_req.data;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         attr_flat <= '0;
      else if (attr_req.we && (attr_req.region < 6'(flash_prot_pkg::REGIONS)))
         attr_flat[2*attr_req.region +: 2] <= attr_req.attr;
   end

   // Refused or idle reads return zero, never a stale word
   wire logic [flash_prot_pkg::WORD_W-1:0] fetch_word;
   wire logic [flash_prot_pkg::WORD_W-1:0] data_word;
   assign fetch_word = (fetch_req.valid && fetch_ok) ? array_mem[fetch_req.addr]
      : flash_prot_pkg::DENIED_WORD;
   assign data_word = (data_req.valid && data_ok) ? array_mem[data_req.addr]
      : flash_prot_pkg::DENIED_WORD;

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         fetch_rsp <= '0;
      else
      begin
         fetch_rsp.ack <= fetch_req.valid;
         fetch_rsp.denied <= fetch_bad;
         fetch_rsp.data <= fetch_word;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         data_rsp <= '0;
      else
      begin
         data_rsp.ack <= data_req.valid;
         data_rsp.denied <= data_bad;
         data_rsp.data <= data_word;
      end
   end

   // Status outputs
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         op_busy <= 1'b0;
         op_done <= 1'b0;
         op_refused <= 1'b0;
         violation <= 1'b0;
      end
      else
      begin
         op_busy <= next_state == flash_prot_pkg::ST_ERASE;
         op_done <= op_finish;
         op_refused <= op_reject;
         violation <= next_violation;
      end
   end
endmodule // flash_block_protection

/* File: bench/flash_block_protection_assertions.sv */
// Port assertions for the flash protection block
`timescale 1ns/100ps
module flash_block_protection_assertions
(
   // Watched ports
   input wire logic core_clk,
   input wire logic rstn,
   input wire flash_prot_pkg::read_req_t fetch_req,
   input wire flash_prot_pkg::read_rsp_t fetch_rsp,
   input wire flash_prot_pkg::read_req_t data_req,
   input wire flash_prot_pkg::read_rsp_t data_rsp,
   input wire logic op_busy,
   input wire logic op_done,
   input wire logic op_refused,
   input wire logic violation_clear,
   input wire logic violation
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_fetch_one_cycle:
      assert property (fetch_req.valid |=> fetch_rsp.ack) else $error("fetch late");
   a_data_one_cycle:
      assert property (data_req.valid |=> data_rsp.ack) else $error("data late");
   a_no_stray_ack:
      assert property (!data_req.valid |=> !data_rsp.ack) else $error("stray ack");
   a_array_end:
      assert property (fetch_req.valid && fetch_req.addr >= 15'h6000 |=> fetch_rsp.denied)
         else $error("end open");
   a_flag_on_refuse:
      assert property (op_refused || data_rsp.denied |-> violation) else $error("no flag");
   a_flag_sticky:
      assert property (violation && !violation_clear |=> violation) else $error("flag lost");
   a_erase_span:
      assert property ($rose(op_busy) |-> ##256 op_done && !op_busy) else $error("span");
   a_refuse_quiet:
      assert property (op_refused |-> !op_done && !op_busy) else $error("refused ran");
   c_erase: cover property ($rose(op_busy));
   c_denied: cover property (data_rsp.denied);
   c_refused: cover property (op_refused);
endmodule // flash_block_protection_assertions

bind flash_block_protection flash_block_protection_assertions u_chk (.*);

/* File: bench/cpu_bus_model.sv */
// Processor fetch and data ports issuing reads side by side
`timescale 1ns/100ps
module cpu_bus_model
(
   // Clock
   input wire logic core_clk,
   // Answers
   input wire flash_prot_pkg::read_rsp_t fetch_rsp,
   input wire flash_prot_pkg::read_rsp_t data_rsp,
   // Requests
   output flash_prot_pkg::read_req_t fetch_req,
   output flash_prot_pkg::read_req_t data_req
);
   initial
   begin
      fetch_req = '0;
      data_req = '0;
   end
   task automatic rd(input logic [14:0] a, output flash_prot_pkg::read_rsp_t f,
      output flash_prot_pkg::read_rsp_t d);
      @(posedge core_clk);
      #1;
      fetch_req = {2'b10, a};
      data_req = {1'b1, 1'($urandom), a};
      @(posedge core_clk);
      #1;
      f = fetch_rsp;
      d = data_rsp;
      // Inverted when idle, so a stale address never looks valid
      fetch_req = {2'b00, ~a};
      data_req = {2'b00, ~a};
   endtask
endmodule // cpu_bus_model

/* File: bench/tb_flash_block_protection.sv */
// Self-checking bench for the flash protection block
`timescale 1ns/100ps
module tb_flash_block_protection;
   logic core_clk, rstn, violation_clear, op_busy, op_done, op_refused, violation;
   flash_prot_pkg::read_req_t fetch_req, data_req;
   flash_prot_pkg::read_rsp_t fetch_rsp, data_rsp;
   flash_prot_pkg::op_req_t op_req;
   flash_prot_pkg::attr_req_t attr_req;
   logic [31:0] mem [int];
   int attr [64];
   int viol, bad_count, checks, cyc;
   logic [14:0] a;
   flash_block_protection u_flash_block_protection (.core_clk(core_clk), .rstn(rstn),
      .fetch_req(fetch_req), .fetch_rsp(fetch_rsp), .data_req(data_req), .data_rsp(data_rsp),
      .op_req(op_req), .op_busy(op_busy), .op_done(op_done), .op_refused(op_refused),
      .attr_req(attr_req), .violation_clear(violation_clear), .violation(violation));
   cpu_bus_model u_cpu_bus_model (.core_clk(core_clk), .fetch_rsp(fetch_rsp),
      .data_rsp(data_rsp), .fetch_req(fetch_req), .data_req(data_req));
   initial
   begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         end_sim;
      end
   end
   task end_sim;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [33:0] e, input logic [33:0] g);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task step;
      @(posedge core_clk);
      #1;
   endtask
   task rd(input logic [14:0] x);
      flash_prot_pkg::read_rsp_t f, d;
      logic fd, dd;
      fd = x >= 15'h6000;
      dd = fd || attr[x[14:9]] == 2;
      viol |= dd;
      u_cpu_bus_model.rd(x, f, d);
      chk("fetch", {1'b1, fd, fd ? 32'h0 : mem[x]}, f);
      chk("data", {1'b1, dd, dd ? 32'h0 : mem[x]}, d);
   endtask
   // Erase flag e picks the operation
   task op(input logic e, input logic [14:0] x);
      logic [31:0] w;
      logic r;
      int n;
      w = $urandom;
      r = x >= 15'h6000 || attr[x[14:9]] != 0;
      step;
      op_req = {e ? flash_prot_pkg::OP_ERASE : flash_prot_pkg::OP_PROGRAM, x, w};
      step;
      op_req = {flash_prot_pkg::OP_NONE, ~x, ~w};
      chk("refused", r, op_refused);
      chk("busy", e && !r, op_busy);
      for (n = 0; e && !r && op_done !== 1'b1 && n < 300; n++)
         step;
      chk("done", !r, op_done);
      chk("span", e && !r ? 256 : 0, n);
      chk("idle", 0, op_busy);
      viol |= r;
      if (!r && !e)
         mem[x] = w;
      for (int i = 0; i < 256 && e && !r; i++)
         mem[{x[14:8], 8'(i)}] = 32'hffffffff;
   endtask
   task clr;
      chk("flag", viol, violation);
      step;
      violation_clear = 1;
      step;
      violation_clear = 0;
      viol = 0;
      chk("cleared", 0, violation);
   endtask
   initial
   begin
      void'($urandom(32'h394d5e72));
      rstn = 0;
      violation_clear = 0;
      op_req = '0;
      attr_req = '0;
      repeat (6) @(posedge core_clk);
      #1;
      rstn = 1;
      repeat (8)
      begin
         a = 15'($urandom % 24576);
         op(0, a);
         rd(a);
      end
      op(0, 15'h0305);
      op(0, 15'h0400);
      op(1, 15'h0377);
      rd(15'h0305);
      rd(15'h0400);
      for (int v = 1; v < 3; v++)
      begin
         a = 15'((10 + v) * 512 + 5);
         op(0, a);
         step;
         attr_req = {1'b1, 6'(10 + v), 2'(v)};
         step;
         attr_req.we = 0;
         attr[10 + v] = v;
         op(0, a);
         op(1, a + 15'h100);
         clr;
         rd(a);
         clr;
      end
      op(0, 15'h1a05);
      rd(15'h1a05);
      rd(15'h6000);
      op(1, 15'h7fff);
      clr;
      // Mid-run reset: flag drops, attributes return to open
      step;
      rstn = 0;
      repeat (2) step;
      rstn = 1;
      viol = 0;
      attr = '{default: 0};
      chk("reset flag", 0, violation);
      op(0, 15'h1805);
      rd(15'h1805);
      op(1, 15'h7fff);
      clr;
      end_sim;
   end
endmodule // tb_flash_block_protection
